// *** rtl/ams_pkg.sv ***
// Constants, field layout and encodings of the operating-mode sequencer
package ams_pkg;
   // Register selection carried in the communications byte
   localparam logic [3:0] REG_MODE_ADDR = 4'h1;
   localparam int COMMS_RD_BIT = 6;
   // Operating-mode register layout and reset value
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam int BIT_RSVD_HI = 7;
   localparam int BIT_BUF_BYPASS = 6;
   localparam int BIT_RSVD_LO = 5;
   localparam int BIT_CHAN_PAIR = 4;
   localparam int BIT_OSC_SHUT = 3;
   localparam int MODE_FIELD_HI = 2;
   // Mode field encodings
   typedef enum logic [2:0] {
      MD_PWRDN  = 3'h0,
      MD_IDLE   = 3'h1,
      MD_SINGLE = 3'h2,
      MD_CONT   = 3'h3,
      MD_ZS_INT = 3'h4,
      MD_FS_INT = 3'h5,
      MD_ZS_SYS = 3'h6,
      MD_FS_SYS = 3'h7
   } ams_mode_t;
   // Serial framing state, Gray along comms -> write data only; comms -> read data flips both bits
   typedef enum logic [1:0] {
      SER_COMMS = 2'h0,
      SER_WDATA = 2'h1,
      SER_RDATA = 2'h3
   } ams_ser_t;
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;
   localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
   // Oscillator start-up time after standby
   localparam int CLK_HZ = 50_000_000;
   localparam int OSC_START_MS = 300;
   localparam int OSC_START_CYC = OSC_START_MS * (CLK_HZ / 1000);
   localparam int OSC_CNT_W = 24;
endpackage

// *** rtl/ams_mode_seq.sv ***
// Operating-mode register, serial access and mode sequencer of the converter pair
module ams_mode_seq #(
   parameter int STARTUP_CYCLES = ams_pkg::OSC_START_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic sclk_in,
   input wire logic sdin_in,
   input wire logic cs_n_in,
   input wire logic main_enable_in,
   input wire logic aux_enable_in,
   input wire logic main_done_in,
   input wire logic aux_done_in,
   output logic sdout_out,
   output logic sdout_oe_n_out,
   output logic [7:0] mode_reg_out,
   output logic buffer_bypass_out,
   output logic main_pseudo_diff_out,
   output logic aux_pair34_allowed_out,
   output logic osc_run_out,
   output logic osc_ready_out,
   output logic pll_on_out,
   output logic excitation_on_out,
   output logic modulator_reset_out,
   output logic adc_reset_out,
   output logic main_power_out,
   output logic aux_power_out,
   output logic main_run_out,
   output logic aux_run_out,
   output logic continuous_out,
   output logic input_short_out,
   output logic ref_to_input_out,
   output logic system_cal_out,
   output logic cal_full_scale_out,
   output logic main_result_ready_out,
   output logic aux_result_ready_out,
   output logic cal_done_out
);
   localparam logic [ams_pkg::OSC_CNT_W-1:0] OSC_LOAD = ams_pkg::OSC_CNT_W'(STARTUP_CYCLES);
   localparam logic [ams_pkg::OSC_CNT_W-1:0] OSC_CNT_ZERO = '0;

   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [2:0] sync3_r;
   logic sclk_s;
   logic sdin_s;
   logic cs_n_s;
   logic sclk_rise;
   logic sclk_fall;
   ams_pkg::ams_ser_t ser_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] tx_r;
   logic [7:0] byte_nxt;
   logic byte_done;
   logic mode_wr;
   logic [7:0] mode_r;
   logic [7:0] mode_nxt;
   ams_pkg::ams_mode_t md;
   logic start_wr;
   logic once_op;
   logic finish;
   logic [1:0] pend_r;
   logic [1:0] pend_live;
   logic main_hit;
   logic aux_hit;
   logic osc_run_r;
   logic osc_run_nxt;
   logic [ams_pkg::OSC_CNT_W-1:0] osc_cnt_r;
   logic osc_ready;

   // Decodes mode values that start a conversion or calibration
   function automatic logic is_start(input logic [2:0] m);
      is_start = (m >= ams_pkg::MD_SINGLE);
   endfunction

   // Decodes mode values that end by themselves and fall back to idle
   function automatic logic is_once(input logic [2:0] m);
      is_once = (m == ams_pkg::MD_SINGLE) || m[2];
   endfunction

   // Pins come from the host's domain: two flops before any use, third for edges
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sync1_r <= 3'h7;
         sync2_r <= 3'h7;
         sync3_r <= 3'h7;
      end else begin
         sync1_r <= {cs_n_in, sdin_in, sclk_in};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   assign sclk_s = sync2_r[0];
   assign sdin_s = sync2_r[1];
   assign cs_n_s = sync2_r[2];
   assign sclk_rise = sclk_s & ~sync3_r[0] & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sync3_r[0] & ~cs_n_s;
   // Incoming bits enter at the bottom, so the first bit ends up as bit seven
   assign byte_nxt = {shift_r[6:0], sdin_s};
   assign byte_done = sclk_rise && (bit_cnt_r == ams_pkg::BIT_CNT_LAST);
   assign mode_wr = byte_done && (ser_r == ams_pkg::SER_WDATA);

   // Serial framing: a comms byte picks the next register and direction
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || cs_n_s) begin
         ser_r <= ams_pkg::SER_COMMS;
         bit_cnt_r <= ams_pkg::BIT_CNT_ZERO;
         shift_r <= 8'h00;
      end else if (sclk_rise) begin
         shift_r <= byte_nxt;
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (byte_done) begin
            case (ser_r)
               ams_pkg::SER_COMMS: begin
                  // Other register addresses belong to neighbouring blocks
                  if (byte_nxt[3:0] != ams_pkg::REG_MODE_ADDR) begin
                     ser_r <= ams_pkg::SER_COMMS;
                  end else if (byte_nxt[ams_pkg::COMMS_RD_BIT]) begin
                     ser_r <= ams_pkg::SER_RDATA;
                  end else begin
                     ser_r <= ams_pkg::SER_WDATA;
                  end
               end
               default: ser_r <= ams_pkg::SER_COMMS;
            endcase
         end
      end
   end

   // Read-back shifter: bit seven first, later bits change on falling edges
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_r <= 8'h00;
         sdout_out <= 1'b0;
         sdout_oe_n_out <= 1'b1;
      end else if (cs_n_s) begin
         sdout_oe_n_out <= 1'b1;
      end else if (byte_done && ser_r == ams_pkg::SER_COMMS) begin
         tx_r <= {mode_r[6:0], 1'b0};
         sdout_out <= mode_r[7];
         sdout_oe_n_out <= !(byte_nxt[ams_pkg::COMMS_RD_BIT] &&
                             byte_nxt[3:0] == ams_pkg::REG_MODE_ADDR);
      end else if (ser_r == ams_pkg::SER_RDATA) begin
         if (sclk_fall && bit_cnt_r != ams_pkg::BIT_CNT_ZERO) begin
            sdout_out <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
         end
      end else begin
         sdout_oe_n_out <= 1'b1;
      end
   end

   // Reserved bits are forced to zero whatever the host sends
   always_comb begin
      mode_nxt = byte_nxt;
      mode_nxt[ams_pkg::BIT_RSVD_HI] = 1'b0;
      mode_nxt[ams_pkg::BIT_RSVD_LO] = 1'b0;
   end

   assign md = ams_pkg::ams_mode_t'(mode_r[ams_pkg::MODE_FIELD_HI:0]);
   assign start_wr = mode_wr && is_start(mode_nxt[2:0]);
   assign once_op = is_once(mode_r[2:0]);
   // Disabled converters are not waited for, so an op with none enabled ends at once
   assign pend_live = pend_r & {aux_enable_in, main_enable_in};
   assign finish = once_op && (pend_live == 2'h0) && !mode_wr;
   assign main_hit = main_done_in && main_run_out;
   assign aux_hit = aux_done_in && aux_run_out;

   // Mode register: host write wins over the automatic return to idle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mode_r <= ams_pkg::MODE_RESET;
      end else if (mode_wr) begin
         mode_r <= mode_nxt;
      end else if (finish) begin
         mode_r[2:0] <= ams_pkg::MD_IDLE;
      end
   end

   // Converters still owing a result for the current single op
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pend_r <= 2'h0;
      end else if (start_wr) begin
         pend_r <= {aux_enable_in, main_enable_in};
      end else begin
         pend_r <= pend_r & ~{aux_hit, main_hit};
      end
   end

   // Ready flags: a new result beats the clearing write; the calibration flag cannot be set in a write cycle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         main_result_ready_out <= 1'b0;
         aux_result_ready_out <= 1'b0;
         cal_done_out <= 1'b0;
      end else begin
         main_result_ready_out <= (main_result_ready_out && !start_wr) || main_hit;
         aux_result_ready_out <= (aux_result_ready_out && !start_wr) || aux_hit;
         cal_done_out <= (cal_done_out && !start_wr) || (finish && mode_r[2]);
      end
   end

   // Oscillator stops only in power-down with shutdown chosen
   assign osc_run_nxt = !(md == ams_pkg::MD_PWRDN && mode_r[ams_pkg::BIT_OSC_SHUT]);
   assign osc_ready = osc_run_r && (osc_cnt_r == OSC_CNT_ZERO);

   // Start-up wait is armed only by a real restart, never when the crystal kept running
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         osc_run_r <= 1'b1;
         osc_cnt_r <= OSC_CNT_ZERO;
      end else begin
         osc_run_r <= osc_run_nxt;
         if (!osc_run_r && osc_run_nxt) begin
            osc_cnt_r <= OSC_LOAD;
         end else if (osc_cnt_r != OSC_CNT_ZERO) begin
            osc_cnt_r <= osc_cnt_r - 1'b1;
         end
      end
   end

   // Analog controls, all registered so the pins never glitch
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mode_reg_out <= ams_pkg::MODE_RESET;
         buffer_bypass_out <= 1'b0;
         main_pseudo_diff_out <= 1'b0;
         aux_pair34_allowed_out <= 1'b1;
         osc_run_out <= 1'b1;
         osc_ready_out <= 1'b0;
         pll_on_out <= 1'b0;
         excitation_on_out <= 1'b0;
         modulator_reset_out <= 1'b1;
         adc_reset_out <= 1'b0;
         main_power_out <= 1'b0;
         aux_power_out <= 1'b0;
         main_run_out <= 1'b0;
         aux_run_out <= 1'b0;
         continuous_out <= 1'b0;
         input_short_out <= 1'b0;
         ref_to_input_out <= 1'b0;
         system_cal_out <= 1'b0;
         cal_full_scale_out <= 1'b0;
      end else begin
         mode_reg_out <= mode_r;
         buffer_bypass_out <= mode_r[ams_pkg::BIT_BUF_BYPASS];
         main_pseudo_diff_out <= mode_r[ams_pkg::BIT_CHAN_PAIR];
         aux_pair34_allowed_out <= !mode_r[ams_pkg::BIT_CHAN_PAIR];
         osc_run_out <= osc_run_r;
         osc_ready_out <= osc_ready;
         pll_on_out <= (md != ams_pkg::MD_PWRDN);
         excitation_on_out <= (md != ams_pkg::MD_PWRDN);
         modulator_reset_out <= !is_start(mode_r[2:0]) || !osc_ready;
         adc_reset_out <= mode_wr;
         main_power_out <= main_enable_in && md != ams_pkg::MD_PWRDN;
         aux_power_out <= aux_enable_in && md != ams_pkg::MD_PWRDN;
         // A write in flight kills the run for one cycle so both converters restart
         main_run_out <= main_enable_in && is_start(mode_r[2:0]) && osc_ready &&
                         !mode_wr && (pend_r[0] || md == ams_pkg::MD_CONT);
         aux_run_out <= aux_enable_in && is_start(mode_r[2:0]) && osc_ready &&
                        !mode_wr && (pend_r[1] || md == ams_pkg::MD_CONT);
         continuous_out <= (md == ams_pkg::MD_CONT);
         input_short_out <= (md == ams_pkg::MD_ZS_INT);
         ref_to_input_out <= (md == ams_pkg::MD_FS_INT);
         system_cal_out <= (md == ams_pkg::MD_ZS_SYS) || (md == ams_pkg::MD_FS_SYS);
         cal_full_scale_out <= (md == ams_pkg::MD_FS_INT) || (md == ams_pkg::MD_FS_SYS);
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_wr_start;
      start_wr;
   endsequence
   sequence s_osc_restart;
      !osc_run_r && osc_run_nxt;
   endsequence

   a_mode_reset_zero: assert property ($rose(rst_n_in) |-> mode_r == ams_pkg::MODE_RESET)
      else $error("mode register not zero after reset");
   a_reserved_bits_zero: assert property (mode_reg_out[7] == 1'b0 && mode_reg_out[5] == 1'b0)
      else $error("reserved mode bits not zero");
   a_write_resets_adcs: assert property (mode_wr |=> adc_reset_out && !main_run_out)
      else $error("mode write did not reset converters");
   a_start_clears_ready: assert property (s_wr_start ##0 !main_hit |=> !main_result_ready_out)
      else $error("start write left main ready set");
   a_once_returns_idle: assert property (finish |=> md == ams_pkg::MD_IDLE ##2 mode_reg_out[2:0] == 3'h1)
      else $error("single op did not return to idle");
   a_cal_sets_flag: assert property (finish && mode_r[2] |=> cal_done_out)
      else $error("calibration end did not flag");
   a_osc_startup_wait: assert property (s_osc_restart |=> !osc_ready [*8])
      else $error("oscillator ready too early");
   a_osc_kept_running: assert property (!mode_r[ams_pkg::BIT_OSC_SHUT] |=> osc_run_r)
      else $error("oscillator stopped with shutdown disabled");
   a_pwrdn_pll_off: assert property (md == ams_pkg::MD_PWRDN |=> !pll_on_out && !excitation_on_out)
      else $error("PLL on in power-down");
   a_disabled_no_run: assert property (!main_enable_in |=> !main_run_out && !main_power_out)
      else $error("disabled main converter running");
   a_buffer_follows: assert property (mode_r[6] |=> buffer_bypass_out)
      else $error("buffer bypass not applied");
   // Decoded analog controls follow the stored mode one cycle later
   a_pair_set_main: assert property (mode_r[4] |=> main_pseudo_diff_out)
      else $error("pseudo-differential main channels not selected");
   a_pair_set_aux: assert property (mode_r[4] |=> !aux_pair34_allowed_out)
      else $error("aux third and fourth input pair still offered");
   a_pair_clear_aux: assert property (!mode_r[4] |=> aux_pair34_allowed_out)
      else $error("aux third and fourth input pair not offered");
   a_idle_mod_reset: assert property (mode_r[2:0] == 3'h1 |=> modulator_reset_out)
      else $error("modulator not held in reset while idle");
   a_cont_updates: assert property (md == ams_pkg::MD_CONT |=> continuous_out)
      else $error("continuous conversion not flagged");
   a_zero_cal_short: assert property (md == ams_pkg::MD_ZS_INT |=> input_short_out)
      else $error("inputs not shorted for zero-scale calibration");
   a_full_cal_ref: assert property (md == ams_pkg::MD_FS_INT |=> ref_to_input_out)
      else $error("reference not routed for full-scale calibration");
   a_sys_zero_cal: assert property (md == ams_pkg::MD_ZS_SYS |=> system_cal_out)
      else $error("system zero-scale calibration not flagged");
   a_sys_full_cal: assert property (md == ams_pkg::MD_FS_SYS |=> cal_full_scale_out)
      else $error("system full-scale calibration not flagged");
endmodule

// *** tb/ams_host_model.sv ***
// Host-side serial master model for the mode sequencer link
module ams_host_model #(
   parameter int HALF_NS = 80
) (
   input wire logic sdo_in,
   output logic sclk_out,
   output logic sdin_out,
   output logic cs_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle link: clock parked high, select released
   initial begin
      sclk_out = 1'b1;
      sdin_out = 1'b0;
      cs_n_out = 1'b1;
   end
   // Data line keeps changing outside frames, so a stale bit is never read as valid
   always #(HALF_NS) if (cs_n_out) sdin_out = ~sdin_out;
   // Command byte then one data byte, bit seven first in both directions
   task automatic frame(input logic [7:0] cmd, input logic [7:0] wdat,
                        output logic [7:0] rdat);
      logic [15:0] tx;
      tx = {cmd, wdat};
      rdat = 8'h00;
      // Offset keeps link edges clear of the system clock edges
      #7 cs_n_out = 1'b0;
      #(HALF_NS);
      for (int i = 15; i >= 0; i--) begin
         sclk_out = 1'b0;
         sdin_out = tx[i];
         #(HALF_NS) sclk_out = 1'b1;
         #50 if (i < 8) rdat[i] = sdo_in;
         #(HALF_NS - 50);
      end
      // Hold select past the last rise so the final byte is not lost
      #(HALF_NS) cs_n_out = 1'b1;
   endtask
endmodule

// *** tb/test_ams_mode_seq.sv ***
// Self-checking bench for the operating-mode register and sequencer
module test_ams_mode_seq;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SU = 20;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic main_enable_in = 1'b0;
   logic aux_enable_in = 1'b0;
   logic main_done_in = 1'b0;
   logic aux_done_in = 1'b0;
   logic sclk, sdin, cs_n, sdout, oe_n, byp, pdiff, p34, osc_run, osc_rdy, pll, exc;
   logic mod_rst, adc_rst, m_pwr, a_pwr, m_run, a_run, cont, shrt, refin, syscal, calfs;
   logic m_rdy, a_rdy, cal_done, sdo_hold, sdo_line;
   logic [7:0] mode;
   int n_fail = 0;
   int checks_done = 0;
   int n_rst = 0;
   int n_lo = 0;
   int seed = 9;
   ams_mode_seq #(.STARTUP_CYCLES(SU)) ams_mode_seq_inst (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .sclk_in(sclk), .sdin_in(sdin), .cs_n_in(cs_n),
      .main_enable_in(main_enable_in), .aux_enable_in(aux_enable_in),
      .main_done_in(main_done_in), .aux_done_in(aux_done_in), .sdout_out(sdout),
      .sdout_oe_n_out(oe_n), .mode_reg_out(mode), .buffer_bypass_out(byp),
      .main_pseudo_diff_out(pdiff), .aux_pair34_allowed_out(p34), .osc_run_out(osc_run),
      .osc_ready_out(osc_rdy), .pll_on_out(pll), .excitation_on_out(exc),
      .modulator_reset_out(mod_rst), .adc_reset_out(adc_rst), .main_power_out(m_pwr),
      .aux_power_out(a_pwr), .main_run_out(m_run), .aux_run_out(a_run),
      .continuous_out(cont), .input_short_out(shrt), .ref_to_input_out(refin),
      .system_cal_out(syscal), .cal_full_scale_out(calfs), .main_result_ready_out(m_rdy),
      .aux_result_ready_out(a_rdy), .cal_done_out(cal_done));
   ams_host_model ams_host_model_inst (.sdo_in(sdo_line), .sclk_out(sclk),
      .sdin_out(sdin), .cs_n_out(cs_n));
   // System clock, 20 ns period
   always #10 clk_in = ~clk_in;
   // Released read line shows the inverse of its last driven level
   always @(posedge clk_in) if (!oe_n) sdo_hold <= sdout;
   assign sdo_line = oe_n ? ~sdo_hold : sdout;
   // Converter reset pulses, and oscillator-not-ready cycles since the last one
   always @(posedge clk_in) begin
      if (adc_rst === 1'b1) n_rst <= n_rst + 1;
      if (adc_rst === 1'b1) n_lo <= 0;
      else if (osc_rdy !== 1'b1) n_lo <= n_lo + 1;
   end
   task automatic chk8(input logic [7:0] e, input logic [7:0] a);
      checks_done++;
      if (a !== e) begin
         n_fail++;
         $display("[ERR] t=%0t exp=%h act=%h", $time, e, a);
      end
   endtask
   task automatic chk1(input logic e, input logic a);
      chk8({7'h00, e}, {7'h00, a});
   endtask
   // One access to the mode register, then settle past the synchronisers
   task automatic xfer(input logic rw, input logic [7:0] v, output logic [7:0] r);
      ams_host_model_inst.frame({1'b0, rw, 2'b00, ams_pkg::REG_MODE_ADDR}, v, r);
      repeat (8) @(posedge clk_in);
      #1;
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Watchdog sized well beyond the expected run of about 9k cycles
   initial begin
      #1_000_000;
      n_fail++;
      results();
   end
   // Main sequence
   initial begin
      logic [7:0] v, r;
      logic [1:0] e;
      int n0;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      #1;
      chk8(8'h00, mode);
      chk1(1'b0, pll);
      chk1(1'b1, p34);
      xfer(1'b1, 8'h00, r);
      chk8(8'h00, r);
      $display("test reset done");
      // Random writes, reserved bits left to the random value; both converters busy meanwhile
      @(posedge clk_in);
      main_enable_in <= 1'b1;
      aux_enable_in <= 1'b1;
      for (int k = 0; k < 24; k++) begin
         v = 8'($random(seed));
         if (k < 8) v[2:0] = k[2:0];
         n0 = n_rst;
         xfer(1'b0, v, r);
         repeat (SU + 4) @(posedge clk_in);
         #1;
         chk8(v & 8'h5F, mode);
         chk8(8'(n0 + 1), 8'(n_rst));
         chk1(v[6], byp);
         chk1(v[4], pdiff);
         chk1(~v[4], p34);
         chk1(v[2:0] != 3'h0, exc);
         chk1(v[2:0] != 3'h0, m_pwr);
         chk1(!(v[2:0] == 3'h0 && v[3]), osc_run);
         chk1(v[2:0] < 3'h2, mod_rst);
         chk1(v[2:0] == 3'h3, cont);
         chk1(v[2:0] == 3'h4, shrt);
         chk1(v[2:0] == 3'h5, refin);
         chk1(v[2:1] == 2'h3, syscal);
         chk1(v[2] & v[0], calfs);
         chk1(v[2:0] >= 3'h2, m_run);
         xfer(1'b1, 8'h00, r);
         chk8(v & 8'h5F, r);
      end
      $display("test random writes done");
      // Standby with oscillator shut, then back out
      xfer(1'b0, 8'h08, r);
      chk1(1'b0, osc_run);
      xfer(1'b0, 8'h09, r);
      repeat (SU + 8) @(posedge clk_in);
      #1;
      // Restart begins the cycle after the write lands, then the whole start-up count
      chk8(8'(SU + 1), 8'(n_lo));
      xfer(1'b0, 8'h00, r);
      xfer(1'b0, 8'h01, r);
      chk8(8'h00, 8'(n_lo));
      $display("test oscillator done");
      // Single conversion and every calibration, random converter enables
      for (int m = 2; m < 8; m++) if (m != 3) begin
         e = 2'($random(seed));
         if (e == 2'h0) e = 2'h1;
         @(posedge clk_in);
         main_enable_in <= e[0];
         aux_enable_in <= e[1];
         xfer(1'b0, 8'(m), r);
         chk1(1'b0, m_rdy);
         chk1(1'b0, cal_done);
         chk1(e[0], m_run);
         chk1(e[1], a_pwr);
         chk1(e[1], a_run);
         @(posedge clk_in);
         main_done_in <= 1'b1;
         aux_done_in <= 1'b1;
         @(posedge clk_in);
         main_done_in <= 1'b0;
         aux_done_in <= 1'b0;
         repeat (5) @(posedge clk_in);
         #1;
         chk1(e[1], a_rdy);
         chk1(e[0], m_rdy);
         chk8(8'h01, mode);
         chk1(m >= 4, cal_done);
      end
      $display("test sequences done");
      // Unmapped register address leaves the mode untouched
      n0 = n_rst;
      ams_host_model_inst.frame(8'h02, 8'hFF, r);
      repeat (8) @(posedge clk_in);
      #1;
      chk8(8'h01, mode);
      chk8(8'(n0), 8'(n_rst));
      $display("test unmapped done");
      // Reset in mid-run must bring the register back to power-down
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      #1;
      chk8(8'h00, mode);
      chk1(1'b0, pll);
      $display("test mid-run reset done");
      results();
   end
endmodule
